// [rtl/pldc_map.svh]
// Offsets, field positions, reset values and timing for the LED control
`ifndef PLDC_MAP_SVH
`define PLDC_MAP_SVH

// ==========================================================
// Register map
`define PLDC_ADDR_W 5
`define PLDC_DATA_W 16
`define PLDC_CFG_OFFSET 5'h14
`define PLDC_CFG_RESET 16'h0422

// ==========================================================
// Field positions
`define PLDC_SEL_W 4
`define PLDC_SEL1_LSB 12
`define PLDC_SEL2_LSB 8
`define PLDC_SEL3_LSB 4
`define PLDC_PER_LSB 2
`define PLDC_PER_W 2
`define PLDC_STR_EN_BIT 1

// ==========================================================
// Timing
`define PLDC_CLK_HZ 10000000
`define PLDC_STRETCH_A_MS 30
`define PLDC_STRETCH_B_MS 60
`define PLDC_STRETCH_C_MS 100
`define PLDC_FAST_HALF_MS 50
`define PLDC_SLOW_HALF_MS 200
`define PLDC_CYC_PER_MS (`PLDC_CLK_HZ / 1000)

`endif

// [rtl/pldc_pkg.sv]
// Types shared by the LED control design
package pldc_pkg;

    // ==========================================================
    // Status inputs from the transceiver core
    typedef struct packed {
        logic speed;
        logic link;
        logic duplex;
        logic tx;
        logic rx;
        logic col;
    } pldc_status_s;

    // ==========================================================
    // Decoded display modes
    typedef enum logic [3:0] {
        PLDC_M_SPEED,
        PLDC_M_TX,
        PLDC_M_RX,
        PLDC_M_COL,
        PLDC_M_LINK,
        PLDC_M_DUPLEX,
        PLDC_M_ACT,
        PLDC_M_ON,
        PLDC_M_OFF,
        PLDC_M_FAST,
        PLDC_M_SLOW,
        PLDC_M_LINK_RX,
        PLDC_M_LINK_ACT,
        PLDC_M_DUP_COL,
        PLDC_M_NONE
    } pldc_mode_e;

endpackage

// [rtl/pldc_blink.sv]
// Free running square wave divider for test blink patterns
`timescale 1ns/1ps
module pldc_blink #(
    parameter int unsigned HALF_CYC = 500000,
    parameter int unsigned CNT_W = 24
) (
    input wire logic sys_clk,
    input wire logic reset,
    output logic phase
);
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    wire wrap = (cnt == CNT_W'(HALF_CYC - 1));

    if (HALF_CYC < 1 || HALF_CYC > (64'd1 << CNT_W)) begin : g_chk
        $error("pldc_blink: HALF_CYC does not fit CNT_W");
    end

    assign next_cnt = wrap ? '0 : cnt + CNT_W'(1);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cnt <= '0;
            phase <= 1'b0;
        end else begin
            cnt <= next_cnt;
            if (wrap) begin
                phase <= ~phase;
            end
        end
    end
endmodule

// [rtl/pldc_stretch.sv]
// Retriggerable event stretcher for one LED
`timescale 1ns/1ps
module pldc_stretch #(
    parameter int unsigned CNT_W = 24
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic event_in,
    input wire logic [CNT_W-1:0] period,
    output logic held
);
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;

    // Reload while the event is high, so timing runs from the last one
    assign next_cnt = event_in ? period :
                      (cnt != '0) ? cnt - CNT_W'(1) : cnt;
    assign held = event_in | (cnt != '0);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end
endmodule

// [rtl/pldc_top.sv]
// LED indicator control: config register, decode, stretch and blink
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "pldc_map.svh"
module pldc_top #(
    parameter int unsigned CNT_W = 24,
    parameter int unsigned STRETCH_A_CYC =
        `PLDC_STRETCH_A_MS * `PLDC_CYC_PER_MS,
    parameter int unsigned STRETCH_B_CYC =
        `PLDC_STRETCH_B_MS * `PLDC_CYC_PER_MS,
    parameter int unsigned STRETCH_C_CYC =
        `PLDC_STRETCH_C_MS * `PLDC_CYC_PER_MS,
    parameter int unsigned FAST_HALF_CYC =
        `PLDC_FAST_HALF_MS * `PLDC_CYC_PER_MS,
    parameter int unsigned SLOW_HALF_CYC =
        `PLDC_SLOW_HALF_MS * `PLDC_CYC_PER_MS
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [`PLDC_ADDR_W-1:0] reg_addr,
    input wire logic [`PLDC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`PLDC_DATA_W-1:0] reg_rdata,
    input wire pldc_pkg::pldc_status_s status,
    output logic ind_one_on,
    output logic ind_two_on,
    output logic ind_three_on
);

    // ==========================================================
    // Parameter checks
    // Counts are cast from int, so a wider counter buys nothing
    if (CNT_W < 2 || CNT_W > 32) begin : g_chk_width
        $error("pldc_top: CNT_W out of range");
    end

    // Hold counters must reach the longest period of each code
    if (STRETCH_A_CYC < 1 ||
        STRETCH_A_CYC >= (64'd1 << CNT_W)) begin : g_chk_a
        $error("pldc_top: STRETCH_A_CYC does not fit CNT_W");
    end

    if (STRETCH_B_CYC < 1 ||
        STRETCH_B_CYC >= (64'd1 << CNT_W)) begin : g_chk_b
        $error("pldc_top: STRETCH_B_CYC does not fit CNT_W");
    end

    if (STRETCH_C_CYC < 1 ||
        STRETCH_C_CYC >= (64'd1 << CNT_W)) begin : g_chk_c
        $error("pldc_top: STRETCH_C_CYC does not fit CNT_W");
    end

    if (FAST_HALF_CYC < 1 ||
        FAST_HALF_CYC > (64'd1 << CNT_W)) begin : g_chk_fast
        $error("pldc_top: FAST_HALF_CYC does not fit CNT_W");
    end

    if (SLOW_HALF_CYC < 1 ||
        SLOW_HALF_CYC > (64'd1 << CNT_W)) begin : g_chk_slow
        $error("pldc_top: SLOW_HALF_CYC does not fit CNT_W");
    end

    // Equal rates would make the two test patterns look alike
    if (FAST_HALF_CYC >= SLOW_HALF_CYC) begin : g_chk_rates
        $error("pldc_top: fast blink must be faster than slow");
    end

    // ==========================================================
    // Configuration register
    logic [`PLDC_DATA_W-1:0] cfg;
    logic [`PLDC_DATA_W-1:0] next_rdata;
    wire cfg_hit = (reg_addr == `PLDC_CFG_OFFSET);
    wire cfg_wr = reg_wr && cfg_hit;
    wire cfg_rd = reg_rd && cfg_hit;
    // Bit 0 reserved: not stored, reads as zero
    wire [`PLDC_DATA_W-1:0] cfg_wval =
        {reg_wdata[`PLDC_DATA_W-1:1], 1'b0};

    // Unmapped reads return zero
    assign next_rdata =
        cfg_rd ? cfg : '0;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cfg <= `PLDC_CFG_RESET;
        end else if (cfg_wr) begin
            cfg <= cfg_wval;
        end
    end

    // ==========================================================
    // Read data register
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // ==========================================================
    // Global stretch controls
    wire stretch_en = cfg[`PLDC_STR_EN_BIT];
    wire [`PLDC_PER_W-1:0] stretch_period_sel =
        cfg[`PLDC_PER_LSB +: `PLDC_PER_W];
    logic [CNT_W-1:0] period_cyc;

    // ==========================================================
    // Stretch period select
    // Hold count is one less: the event cycle itself counts too.
    wire [CNT_W-1:0] hold_a = CNT_W'(STRETCH_A_CYC - 1);
    wire [CNT_W-1:0] hold_b = CNT_W'(STRETCH_B_CYC - 1);
    wire [CNT_W-1:0] hold_c = CNT_W'(STRETCH_C_CYC - 1);
    wire per_a = (stretch_period_sel == 2'h0);
    wire per_b = (stretch_period_sel == 2'h1);

    // Reserved code 11 falls back to the longest period.
    assign period_cyc =
        per_a ? hold_a :
        per_b ? hold_b :
        hold_c;

    // ==========================================================
    // Test blink sources
    logic fast_phase;
    logic slow_phase;

    pldc_blink #(
        .HALF_CYC(FAST_HALF_CYC),
        .CNT_W(CNT_W)
    ) u_fast (
        .sys_clk(sys_clk),
        .reset(reset),
        .phase(fast_phase)
    );

    pldc_blink #(
        .HALF_CYC(SLOW_HALF_CYC),
        .CNT_W(CNT_W)
    ) u_slow (
        .sys_clk(sys_clk),
        .reset(reset),
        .phase(slow_phase)
    );

    // ==========================================================
    // Selector decode, shared by all three LEDs
    function automatic logic [`PLDC_SEL_W-1:0] sel_of(
        input logic [`PLDC_DATA_W-1:0] c,
        input int idx
    );
        logic [`PLDC_SEL_W-1:0] s;
        if (idx == 0) begin
            s = c[`PLDC_SEL1_LSB +: `PLDC_SEL_W];
        end else if (idx == 1) begin
            s = c[`PLDC_SEL2_LSB +: `PLDC_SEL_W];
        end else begin
            s = c[`PLDC_SEL3_LSB +: `PLDC_SEL_W];
        end
        return s;
    endfunction

    // LED two takes 1101 for link plus activity, the others 1110;
    // the sibling code carries the duplex plus collision display.
    function automatic pldc_pkg::pldc_mode_e mode_of(
        input logic [`PLDC_SEL_W-1:0] s,
        input int idx
    );
        pldc_pkg::pldc_mode_e m;
        case (s)
            4'h0: m = pldc_pkg::PLDC_M_SPEED;
            4'h1: m = pldc_pkg::PLDC_M_TX;
            4'h2: m = pldc_pkg::PLDC_M_RX;
            4'h3: m = pldc_pkg::PLDC_M_COL;
            4'h4: m = pldc_pkg::PLDC_M_LINK;
            4'h5: m = pldc_pkg::PLDC_M_DUPLEX;
            4'h7: m = pldc_pkg::PLDC_M_ACT;
            4'h8: m = pldc_pkg::PLDC_M_ON;
            4'h9: m = pldc_pkg::PLDC_M_OFF;
            4'ha: m = pldc_pkg::PLDC_M_FAST;
            4'hb: m = pldc_pkg::PLDC_M_SLOW;
            4'hc: m = pldc_pkg::PLDC_M_LINK_RX;
            4'hd: m = (idx == 1) ? pldc_pkg::PLDC_M_LINK_ACT :
                      pldc_pkg::PLDC_M_DUP_COL;
            4'he: m = (idx == 1) ? pldc_pkg::PLDC_M_DUP_COL :
                      pldc_pkg::PLDC_M_LINK_ACT;
            default: m = pldc_pkg::PLDC_M_NONE;
        endcase
        return m;
    endfunction

    // Raw event that feeds the stretcher for a mode
    function automatic logic event_of(
        input pldc_pkg::pldc_mode_e m,
        input pldc_pkg::pldc_status_s st
    );
        logic e;
        case (m)
            pldc_pkg::PLDC_M_TX: e = st.tx;
            pldc_pkg::PLDC_M_RX: e = st.rx;
            pldc_pkg::PLDC_M_COL: e = st.col;
            pldc_pkg::PLDC_M_ACT: e = st.rx | st.tx;
            pldc_pkg::PLDC_M_LINK_RX:
                e = st.rx;
            pldc_pkg::PLDC_M_LINK_ACT:
                e = st.rx | st.tx;
            pldc_pkg::PLDC_M_DUP_COL:
                e = st.col;
            default: e = 1'b0;
        endcase
        return e;
    endfunction

    function automatic logic is_combined(input pldc_pkg::pldc_mode_e m);
        return (m == pldc_pkg::PLDC_M_LINK_RX) ||
               (m == pldc_pkg::PLDC_M_LINK_ACT) ||
               (m == pldc_pkg::PLDC_M_DUP_COL);
    endfunction

    // Final LED level for a mode
    function automatic logic level_of(
        input pldc_pkg::pldc_mode_e m,
        input pldc_pkg::pldc_status_s st,
        input logic ev,
        input logic fast,
        input logic slow
    );
        logic v;
        case (m)
            pldc_pkg::PLDC_M_SPEED: v = st.speed;
            pldc_pkg::PLDC_M_LINK: v = st.link;
            pldc_pkg::PLDC_M_DUPLEX: v = st.duplex;
            pldc_pkg::PLDC_M_TX: v = ev;
            pldc_pkg::PLDC_M_RX: v = ev;
            pldc_pkg::PLDC_M_COL: v = ev;
            pldc_pkg::PLDC_M_ACT: v = ev;
            pldc_pkg::PLDC_M_ON: v = 1'b1;
            pldc_pkg::PLDC_M_OFF: v = 1'b0;
            pldc_pkg::PLDC_M_FAST: v = fast;
            pldc_pkg::PLDC_M_SLOW: v = slow;
            // Primary sets the level, the event toggles it at the fast rate
            pldc_pkg::PLDC_M_LINK_RX:
                v = st.link ^ (ev & fast);
            pldc_pkg::PLDC_M_LINK_ACT:
                v = st.link ^ (ev & fast);
            pldc_pkg::PLDC_M_DUP_COL:
                v = st.duplex ^ (ev & fast);
            default: v = 1'b0;
        endcase
        return v;
    endfunction

    // ==========================================================
    // Per-LED datapath
    logic [2:0] next_led;

    // Selector changes keep the stretcher running
    for (genvar i = 0; i < 3; i++) begin : g_led
        wire [`PLDC_SEL_W-1:0] sel = sel_of(cfg, i);
        wire pldc_pkg::pldc_mode_e mode = mode_of(sel, i);
        wire raw_ev = event_of(mode, status);
        wire held;
        wire combined = is_combined(mode);
        // Combined displays ignore the global enable
        wire use_stretch = stretch_en | combined;
        wire shown_ev = use_stretch ? held : raw_ev;

        pldc_stretch #(
            .CNT_W(CNT_W)
        ) u_stretch (
            .sys_clk(sys_clk),
            .reset(reset),
            .event_in(raw_ev),
            .period(period_cyc),
            .held(held)
        );

        assign next_led[i] =
            level_of(mode, status, shown_ev, fast_phase, slow_phase);
    end

    // ==========================================================
    // Output registers
    // Each output straight from its own flop
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ind_one_on <= 1'b0;
        end else begin
            ind_one_on <= next_led[0];
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ind_two_on <= 1'b0;
        end else begin
            ind_two_on <= next_led[1];
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ind_three_on <= 1'b0;
        end else begin
            ind_three_on <= next_led[2];
        end
    end

endmodule

// [verification/pldc_top_chk.sv]
// Assertion checker for the LED control block
`timescale 1ns/1ps
`include "pldc_map.svh"
module pldc_top_chk (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [`PLDC_ADDR_W-1:0] reg_addr,
    input wire logic [`PLDC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`PLDC_DATA_W-1:0] reg_rdata,
    input wire pldc_pkg::pldc_status_s status,
    input wire logic ind_one_on,
    input wire logic ind_two_on,
    input wire logic ind_three_on
);
    // ========================================
    // Shadow config, so selectors are known here
    logic [15:0] cfg;
    logic hit;
    assign hit = reg_addr == 5'h14;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cfg <= 16'h0422;
        end else if (reg_wr && hit) begin
            cfg <= reg_wdata & 16'hfffe;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // ========================================
    // Assertions
    chk_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 16'h0) else $error("read data not idle");
    chk_read_back: assert property (
        reg_rd && hit |=> reg_rdata == $past(cfg)) else $error("bad read");
    chk_unmapped_read: assert property (
        reg_rd && !hit |=> reg_rdata == 16'h0) else $error("unmapped read");
    chk_force_on: assert property (
        cfg[15:12] == 4'h8 |=> ind_one_on) else $error("led not forced on");
    chk_force_off: assert property (
        cfg[11:8] == 4'h9 |=> !ind_two_on) else $error("led not forced off");
    chk_link_follow: assert property (
        cfg[7:4] == 4'h4 |=> ind_three_on == $past(status.link))
        else $error("link not followed");
    chk_speed_follow: assert property (
        cfg[15:12] == 4'h0 |=> ind_one_on == $past(status.speed))
        else $error("speed not followed");
    chk_raw_event: assert property (
        cfg[7:4] == 4'h1 && !cfg[1] |=> ind_three_on == $past(status.tx))
        else $error("event not raw");
    chk_stretch_hold: assert property (
        cfg[7:4] == 4'h1 && cfg[1] && status.tx |=> ind_three_on [*8])
        else $error("event not held");
    chk_unused_off: assert property (
        cfg[11:8] == 4'h6 |=> !ind_two_on) else $error("unused code lit");
endmodule

bind pldc_top pldc_top_chk chk_u (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .status(status), .ind_one_on(ind_one_on),
    .ind_two_on(ind_two_on), .ind_three_on(ind_three_on)
);

// [verification/pldc_top_test.sv]
// Self-checking testbench for the LED control block
`timescale 1ns/1ps
module pldc_top_test;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [4:0] reg_addr = 5'h0;
    logic [15:0] reg_wdata = 16'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    pldc_pkg::pldc_status_s status = '0;
    pldc_pkg::pldc_status_s s;
    logic [2:0] leds;
    logic [2:0] z;
    logic [3:0] c;
    logic [15:0] v;
    logic [15:0] d;
    logic prev;
    int mismatches = 0;
    int checked = 0;
    int n;
    int g;

    // Short counts keep the run small
    pldc_top #(.STRETCH_A_CYC(10), .STRETCH_B_CYC(20), .STRETCH_C_CYC(30),
        .FAST_HALF_CYC(4), .SLOW_HALF_CYC(16)) dut_u (
        .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .status(status), .ind_one_on(leds[2]),
        .ind_two_on(leds[1]), .ind_three_on(leds[0]));

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    // ========================================
    // Helpers
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] val);
        reg_addr <= a;
        reg_wdata <= val;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] val);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 val = reg_rdata;
    endtask
    function automatic logic led_of(logic [3:0] m, pldc_pkg::pldc_status_s t);
        case (m)
            4'h0: led_of = t.speed;
            4'h1: led_of = t.tx;
            4'h2: led_of = t.rx;
            4'h3: led_of = t.col;
            4'h4: led_of = t.link;
            4'h5: led_of = t.duplex;
            4'h7: led_of = t.rx | t.tx;
            4'h8: led_of = 1'b1;
            default: led_of = 1'b0;
        endcase
    endfunction
    task automatic final_report();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Hang guard, far beyond the expected length
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        final_report();
    end

    // ========================================
    // Tests
    initial begin
        void'($urandom(32'hb97748d4));
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        rd(5'h14, d);
        chk(d, 16'h0422);
        for (int i = 0; i < 8; i++) begin
            v = 16'($urandom);
            wr(5'h14, v);
            wr(5'h0f, ~v);
            rd(5'h14, d);
            chk(d, v & 16'hfffe);
            rd(5'h0f, d);
            chk(d, 16'h0);
        end
        $display("register test done");
        for (int k = 0; k < 11; k++) begin
            c = (k == 10) ? 4'hf : 4'(k);
            wr(5'h14, {c, c, c, 4'h0});
            for (int i = 0; i < 20; i++) begin
                s = pldc_pkg::pldc_status_s'(6'($urandom));
                status <= s;
                cyc(1);
                chk({13'h0, leds}, {13'h0, {3{led_of(c, s)}}});
            end
        end
        status <= '0;
        $display("single code test done");
        for (int k = 10; k < 12; k++) begin
            c = 4'(k);
            wr(5'h14, {c, c, c, 4'h0});
            cyc(2);
            n = 0;
            for (int i = 0; i < 64; i++) begin
                prev = leds[0];
                cyc(1);
                n += int'(leds[0] != prev);
            end
            chk(16'(n), (k == 10) ? 16'h0010 : 16'h0004);
        end
        $display("blink test done");
        for (int p = 0; p < 4; p++) begin
            g = $urandom_range(8, 1);
            wr(5'h14, {8'h04, 4'h1, 2'(p), 2'b10});
            n = 0;
            for (int i = 0; i < 120; i++) begin
                status.tx <= (i == 0 || i == g);
                cyc(1);
                n += int'(leds[0]);
            end
            chk(16'(n), 16'(g + ((p == 0) ? 10 : (p == 1) ? 20 : 30)));
        end
        $display("stretch period test done");
        for (int k = 12; k < 15; k++) begin
            // Stretch enable off: combined displays must still blink
            wr(5'h14, {4'he, 4'(k), 4'hd, 4'h0});
            s = '0;
            s.link = 1'b1;
            s.duplex = 1'b1;
            status <= s;
            cyc(30);
            chk({13'h0, leds}, 16'h0007);
            status <= pldc_pkg::pldc_status_s'(s | 6'h07);
            cyc(1);
            status <= s;
            z = 3'h0;
            for (int i = 0; i < 12; i++) begin
                cyc(1);
                z = z | ~leds;
            end
            chk({13'h0, z}, 16'h0007);
        end
        $display("combined test done");
        final_report();
    end
endmodule
